// >>> core/lpas_defines.vh
// Purpose: constants for the lens position adc sequencer
// Assumes: 8-bit register port, 50 MHz clk
// Notes:   offsets are byte indices on the register port
`ifndef LPAS_DEFINES_VH
`define LPAS_DEFINES_VH
// register offsets
`define LPAS_REG_CTRL     4'h0
`define LPAS_REG_LED      4'h1
`define LPAS_REG_SETL_LO  4'h2
`define LPAS_REG_SETL_HI  4'h3
`define LPAS_REG_RES_LO   4'h4
`define LPAS_REG_RES_HI   4'h5
`define LPAS_REG_THR_LO   4'h6
`define LPAS_REG_THR_HI   4'h7
`define LPAS_REG_STATUS   4'h8
`define LPAS_REG_IRQ_STAT 4'h9
`define LPAS_REG_IRQ_MASK 4'hA
`define LPAS_REG_ADC_DIV  4'hB
// ctrl fields
`define LPAS_CTRL_START   0
`define LPAS_CTRL_ZOOM    1
`define LPAS_CTRL_AVG     2
`define LPAS_CTRL_CURR    3
`define LPAS_CTRL_THR_EN  4
// irq / status fields
`define LPAS_IRQ_DONE     0
`define LPAS_IRQ_THR      1
`define LPAS_ST_BUSY      0
`define LPAS_ST_DRV_OFF   1
// reset values
`define LPAS_CTRL_RST     8'h04
`define LPAS_ADC_DIV_RST  8'h03
`define LPAS_THR_RST      12'hFFF
// timing
`define LPAS_CLK_MHZ      50
`define LPAS_SETTLE_MAX_US 10'd1000
`define LPAS_AVG_SAMPLES  4
`endif

// >>> core/lpas_adc_if.v
// Purpose: converter clock divider and conversion handshake
// Assumes: converter answers on a pin-level done from its own timing
// Notes:   done passes three flops; a rise counts once stages 2 and 3 agree
`timescale 1ns/1ps
module lpas_adc_if #(
    parameter DIV_W = 8
) (
    // clock and reset
    input  wire             clk,
    input  wire             rst,
    // control from sequencer
    input  wire [DIV_W-1:0] div,
    input  wire             conv_req,
    output reg              smp_valid,
    output reg  [11:0]      smp_data,
    // converter pins
    output reg              adc_clk_en,
    output reg              adc_convert,
    input  wire             adc_done,
    input  wire [11:0]      adc_data
);
    reg [DIV_W-1:0] div_cnt_q;
    reg [2:0]       done_sync_q;
    reg             done_lvl_q;

    // converter clock is the master clock divided by div+1
    always @(posedge clk) begin
        if (rst) begin
            div_cnt_q  <= {DIV_W{1'b0}};
            adc_clk_en <= 1'b0;
        end else if (div_cnt_q >= div) begin
            div_cnt_q  <= {DIV_W{1'b0}};
            adc_clk_en <= 1'b1;
        end else begin
            div_cnt_q  <= div_cnt_q + 1'b1;
            adc_clk_en <= 1'b0;
        end
    end

    // done synchroniser; stage 1 is read only by stage 2
    always @(posedge clk) begin
        if (rst) begin
            done_sync_q <= 3'h0;
            done_lvl_q  <= 1'b0;
        end else begin
            done_sync_q <= {done_sync_q[1:0], adc_done};
            if (done_sync_q[1] == done_sync_q[2])
                done_lvl_q <= done_sync_q[2];
        end
    end

    // convert is held until done rises; data is stable by then
    always @(posedge clk) begin
        if (rst) begin
            adc_convert <= 1'b0;
            smp_valid   <= 1'b0;
            smp_data    <= 12'h000;
        end else begin
            smp_valid <= 1'b0;
            if (conv_req && !adc_convert && !done_lvl_q)
                adc_convert <= 1'b1;
            else if (adc_convert && done_sync_q[1] && done_sync_q[2] && !done_lvl_q) begin
                adc_convert <= 1'b0;
                smp_valid   <= 1'b1;
                smp_data    <= adc_data;
            end
        end
    end
endmodule // lpas_adc_if

// >>> core/lpas_seq.v
// Purpose: lens position measurement sequencer with settle, averaging, threshold
// Assumes: 8-bit register port, read data one cycle after read strobe
// Notes:   one measurement at a time; start is ignored while busy
//
// Behaviour
// - wait a programmed settle time of 0 to 1000 us before converting
// - with averaging on, take four back-to-back samples and store their mean
// - the 12-bit result sits split across two byte result registers
// - with averaging off, one conversion result is stored
// - one control bit picks current or voltage conversion
// - converter clock is divided down from the master clock
// - a 4-bit code sets LED drive current, 4 mA to 19 mA
// - only the LED of the lens being measured carries current
// - reaching the programmed threshold disables the output drivers
// - never more than one measurement, never focus and zoom together
// - zoom voltage mode sources Hall current and converts the sense pair
`timescale 1ns/1ps
`include "lpas_defines.vh"
module lpas_seq #(
    parameter DIV_W = 8
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst,
    // register port
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // converter
    output wire       adc_clk_en,
    output wire       adc_convert,
    output reg        adc_mode_current,
    output reg        adc_sel_diff,
    input  wire       adc_done,
    input  wire [11:0] adc_data,
    // sensor drive
    output reg  [3:0] led_current_source,
    output reg        focus_led,
    output reg        zoom_led,
    output reg        zoom_hall_source_pin,
    // driver disable and interrupt
    output reg        drv_disable,
    output wire       irq
);
    // sequencer states
    localparam ST_IDLE   = 2'h0;
    localparam ST_SETTLE = 2'h1;
    localparam ST_CONV   = 2'h2;
    localparam ST_STORE  = 2'h3;
    localparam US_CYC    = `LPAS_CLK_MHZ;
    localparam US_W      = 6;

    reg  [7:0]       ctrl_q;
    reg  [3:0]       led_q;
    reg  [9:0]       settle_q;
    reg  [11:0]      res_q;
    reg  [11:0]      thr_q;
    reg  [1:0]       irq_stat_q;
    reg  [1:0]       irq_mask_q;
    reg  [DIV_W-1:0] div_q;
    reg  [1:0]       st_q;
    reg  [US_W-1:0]  us_cnt_q;
    reg  [9:0]       settle_cnt_q;
    reg  [1:0]       smp_cnt_q;
    reg  [13:0]      sum_q;
    reg              zoom_q;
    reg              avg_q;
    reg              conv_req_q;
    wire             smp_valid;
    wire [11:0]      smp_data;
    wire             start_wr;
    wire             done_ev;
    wire             thr_ev;
    wire [9:0]       settle_lim;
    wire [13:0]      sum_d;

    assign start_wr   = reg_wr && (reg_addr == `LPAS_REG_CTRL) && reg_wdata[`LPAS_CTRL_START];
    // clamp programmed settle to the documented ceiling
    assign settle_lim = (settle_q > `LPAS_SETTLE_MAX_US) ? `LPAS_SETTLE_MAX_US : settle_q;
    assign sum_d      = sum_q + {2'h0, smp_data};
    assign done_ev    = (st_q == ST_STORE);
    // compare every fresh sample when enabled
    assign thr_ev     = smp_valid && ctrl_q[`LPAS_CTRL_THR_EN] && (smp_data >= thr_q);
    assign irq        = |(irq_stat_q & irq_mask_q);

    lpas_adc_if #(
        .DIV_W (DIV_W)
    ) u_adc_if (
        .clk         (clk),
        .rst         (rst),
        .div         (div_q),
        .conv_req    (conv_req_q),
        .smp_valid   (smp_valid),
        .smp_data    (smp_data),
        .adc_clk_en  (adc_clk_en),
        .adc_convert (adc_convert),
        .adc_done    (adc_done),
        .adc_data    (adc_data)
    );

    // configuration registers written by software
    always @(posedge clk) begin
        if (rst) begin
            ctrl_q     <= `LPAS_CTRL_RST;
            led_q      <= 4'h0;
            settle_q   <= 10'h000;
            thr_q      <= `LPAS_THR_RST;
            irq_mask_q <= 2'h0;
            div_q      <= `LPAS_ADC_DIV_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                `LPAS_REG_CTRL:     ctrl_q <= {reg_wdata[7:1], 1'b0};
                `LPAS_REG_LED:      led_q <= reg_wdata[3:0];
                `LPAS_REG_SETL_LO:  settle_q[7:0] <= reg_wdata;
                `LPAS_REG_SETL_HI:  settle_q[9:8] <= reg_wdata[1:0];
                `LPAS_REG_THR_LO:   thr_q[7:0] <= reg_wdata;
                `LPAS_REG_THR_HI:   thr_q[11:8] <= reg_wdata[3:0];
                `LPAS_REG_IRQ_MASK: irq_mask_q <= reg_wdata[1:0];
                `LPAS_REG_ADC_DIV:  div_q <= reg_wdata[DIV_W-1:0];
                default: ;
            endcase
        end
    end

    // interrupt status: hardware set wins over a write-one clear
    always @(posedge clk) begin
        if (rst) begin
            irq_stat_q <= 2'h0;
        end else begin
            if (reg_wr && reg_addr == `LPAS_REG_IRQ_STAT)
                irq_stat_q <= (irq_stat_q & ~reg_wdata[1:0]) | {thr_ev, done_ev};
            else
                irq_stat_q <= irq_stat_q | {thr_ev, done_ev};
        end
    end

    // driver disable latches on threshold until software clears it via status write
    always @(posedge clk) begin
        if (rst) begin
            drv_disable <= 1'b0;
        end else if (thr_ev) begin
            drv_disable <= 1'b1;
        end else if (reg_wr && reg_addr == `LPAS_REG_STATUS && reg_wdata[`LPAS_ST_DRV_OFF]) begin
            drv_disable <= 1'b0;
        end
    end

    // measurement sequencer; start is refused while busy so only one runs
    always @(posedge clk) begin
        if (rst) begin
            st_q         <= ST_IDLE;
            us_cnt_q     <= {US_W{1'b0}};
            settle_cnt_q <= 10'h000;
            smp_cnt_q    <= 2'h0;
            sum_q        <= 14'h0000;
            zoom_q       <= 1'b0;
            avg_q        <= 1'b0;
            conv_req_q   <= 1'b0;
            res_q        <= 12'h000;
        end else begin
            conv_req_q <= 1'b0;
            case (st_q)
                ST_IDLE: begin
                    if (start_wr) begin
                        zoom_q       <= reg_wdata[`LPAS_CTRL_ZOOM];
                        avg_q        <= reg_wdata[`LPAS_CTRL_AVG];
                        us_cnt_q     <= {US_W{1'b0}};
                        settle_cnt_q <= 10'h000;
                        smp_cnt_q    <= 2'h0;
                        sum_q        <= 14'h0000;
                        st_q         <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    // count whole microseconds of settle time
                    if (settle_cnt_q >= settle_lim) begin
                        conv_req_q <= 1'b1;
                        st_q       <= ST_CONV;
                    end else if (us_cnt_q == US_CYC - 1) begin
                        us_cnt_q     <= {US_W{1'b0}};
                        settle_cnt_q <= settle_cnt_q + 10'h001;
                    end else begin
                        us_cnt_q <= us_cnt_q + 1'b1;
                    end
                end
                ST_CONV: begin
                    if (smp_valid) begin
                        sum_q <= sum_d;
                        if (!avg_q) begin
                            res_q <= smp_data;
                            st_q  <= ST_STORE;
                        end else if (smp_cnt_q == `LPAS_AVG_SAMPLES - 1) begin
                            res_q <= sum_d[13:2];
                            st_q  <= ST_STORE;
                        end else begin
                            smp_cnt_q  <= smp_cnt_q + 2'h1;
                            conv_req_q <= 1'b1;
                        end
                    end else if (!adc_convert && !conv_req_q) begin
                        conv_req_q <= 1'b1;
                    end
                end
                ST_STORE: st_q <= ST_IDLE;
                default:  st_q <= ST_IDLE;
            endcase
        end
    end

    // sensor drive: one lens at a time, only while a measurement runs
    always @(posedge clk) begin
        if (rst) begin
            focus_led            <= 1'b0;
            zoom_led             <= 1'b0;
            zoom_hall_source_pin <= 1'b0;
            led_current_source   <= 4'h0;
            adc_mode_current     <= 1'b0;
            adc_sel_diff         <= 1'b0;
        end else begin
            adc_mode_current <= ctrl_q[`LPAS_CTRL_CURR];
            adc_sel_diff     <= !ctrl_q[`LPAS_CTRL_CURR];
            if (st_q == ST_SETTLE || st_q == ST_CONV) begin
                focus_led <= ctrl_q[`LPAS_CTRL_CURR] && !zoom_q;
                zoom_led  <= ctrl_q[`LPAS_CTRL_CURR] && zoom_q;
                zoom_hall_source_pin <= !ctrl_q[`LPAS_CTRL_CURR] && zoom_q;
                led_current_source <= ctrl_q[`LPAS_CTRL_CURR] ? led_q : 4'h0;
            end else begin
                focus_led            <= 1'b0;
                zoom_led             <= 1'b0;
                zoom_hall_source_pin <= 1'b0;
                led_current_source   <= 4'h0;
            end
        end
    end

    // read data one cycle after the strobe; unmapped offsets read zero
    always @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `LPAS_REG_CTRL:     reg_rdata <= ctrl_q;
                `LPAS_REG_LED:      reg_rdata <= {4'h0, led_q};
                `LPAS_REG_SETL_LO:  reg_rdata <= settle_q[7:0];
                `LPAS_REG_SETL_HI:  reg_rdata <= {6'h00, settle_q[9:8]};
                `LPAS_REG_RES_LO:   reg_rdata <= res_q[7:0];
                `LPAS_REG_RES_HI:   reg_rdata <= {4'h0, res_q[11:8]};
                `LPAS_REG_THR_LO:   reg_rdata <= thr_q[7:0];
                `LPAS_REG_THR_HI:   reg_rdata <= {4'h0, thr_q[11:8]};
                `LPAS_REG_STATUS:   reg_rdata <= {6'h00, drv_disable, (st_q != ST_IDLE)};
                `LPAS_REG_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_q};
                `LPAS_REG_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_q};
                `LPAS_REG_ADC_DIV:  reg_rdata <= div_q;
                default:            reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule // lpas_seq

// >>> dv/lpas_seq_asserts.sv
// Purpose: port-level checks of the lens position sequencer
// Assumes: adc_div left at its reset value of 3
// Notes:   watches design ports only, register port and adc_done inputs as well as outputs
`timescale 1ns/1ps
module lpas_seq_chk (
    // clock and reset
    input wire        clk,
    input wire        rst,
    // register port
    input wire [3:0]  reg_addr,
    input wire [7:0]  reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [7:0]  reg_rdata,
    // converter and drive
    input wire        adc_clk_en,
    input wire        adc_convert,
    input wire        adc_mode_current,
    input wire        adc_sel_diff,
    input wire        adc_done,
    input wire        focus_led,
    input wire        zoom_led,
    input wire        zoom_hall_source_pin,
    input wire        drv_disable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // sensor drive exclusivity and mode
    property p_one_led;
        !(focus_led && zoom_led) && !(focus_led && zoom_hall_source_pin);
    endproperty
    a_one_led: assert property (p_one_led) else $error("two sensors driven");
    property p_led_mode; focus_led || zoom_led |-> adc_mode_current && !adc_sel_diff; endproperty
    a_led_mode: assert property (p_led_mode) else $error("led in voltage mode");
    property p_hall; zoom_hall_source_pin |-> !adc_mode_current && adc_sel_diff; endproperty
    a_hall: assert property (p_hall) else $error("hall in current mode");
    // driver disable only cleared by software
    property p_drv; drv_disable && !(reg_wr && reg_addr == 4'h8 && reg_wdata[1]) |=> drv_disable;
    endproperty
    a_drv: assert property (p_drv) else $error("driver disable dropped");
    property p_rd; !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rd: assert property (p_rd) else $error("read data without strobe");
    // converter clock is master clock over four
    property p_div; adc_clk_en |=> !adc_clk_en [*3] ##1 adc_clk_en; endproperty
    a_div: assert property (p_div) else $error("converter clock spacing");
    property p_fall; $rose(adc_done) && adc_convert |-> ##[2:5] !adc_convert; endproperty
    a_fall: assert property (p_fall) else $error("conversion not ended");
    property p_hold; adc_convert && !adc_done |=> adc_convert; endproperty
    a_hold: assert property (p_hold) else $error("conversion dropped early");
    c_focus: cover property (focus_led);
    c_zoom: cover property (zoom_led);
    c_hall: cover property (zoom_hall_source_pin);
    c_drv: cover property ($rose(drv_disable));
endmodule // lpas_seq_chk
bind lpas_seq lpas_seq_chk u_chk (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .adc_clk_en(adc_clk_en), .adc_convert(adc_convert), .adc_mode_current(adc_mode_current),
    .adc_sel_diff(adc_sel_diff), .adc_done(adc_done), .focus_led(focus_led),
    .zoom_led(zoom_led), .zoom_hall_source_pin(zoom_hall_source_pin),
    .drv_disable(drv_disable));

// >>> dv/lpas_adc_model.sv
// Purpose: behavioural converter beside the sequencer
// Assumes: done held until convert drops
// Notes:   sample n returns base + n mod 4; data toggles while not valid
`timescale 1ns/1ps
module lpas_adc_model (
    input  wire        clk,
    input  wire        adc_convert,
    input  wire [3:0]  dly,
    input  wire [11:0] base,
    output reg         adc_done,
    output reg  [11:0] adc_data
);
    reg [3:0] cnt;
    reg [1:0] k;
    initial begin
        adc_done = 1'b0;
        adc_data = 12'h000;
        cnt = 4'h0;
        k = 2'h0;
    end
    // done dly+1 cycles after convert rises; data only valid around done
    always @(posedge clk) begin
        if (!adc_convert) begin
            if (adc_done) k <= k + 2'h1;
            adc_done <= 1'b0;
            cnt <= 4'h0;
        end else if (cnt == dly) adc_done <= 1'b1;
        else cnt <= cnt + 4'h1;
        adc_data <= (adc_done || (adc_convert && cnt == dly)) ? base + k : ~adc_data;
    end
endmodule // lpas_adc_model

// >>> dv/lpas_seq_bench.sv
// Purpose: directed register-level test of the sequencer
// Assumes: adc_div left at reset value
// Notes:   expected results come from the model's sample pattern
`timescale 1ns/1ps
`include "lpas_defines.vh"
module lpas_seq_bench;
    reg         clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    reg  [3:0]  reg_addr = 4'h0, dly = 4'h3;
    reg  [7:0]  reg_wdata = 8'h00, rd_v;
    reg  [11:0] base = 12'h000, r;
    reg  [1:0]  k_exp = 2'h0;
    reg  [3:0]  code_s;
    reg  [1:0]  md_s;
    reg         seen_f, seen_z, seen_h, conv_s;
    wire [7:0]  reg_rdata;
    wire [3:0]  led_code;
    wire [11:0] adc_data;
    wire        adc_clk_en, adc_convert, adc_mode_current, adc_sel_diff, adc_done;
    wire        focus_led, zoom_led, zoom_hall_source_pin, drv_disable, irq;
    integer     num_errors = 0, checks = 0, cyc = 0, t0, t_conv, i;
    lpas_seq u_lpas_seq (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_clk_en(adc_clk_en),
        .adc_convert(adc_convert), .adc_mode_current(adc_mode_current),
        .adc_sel_diff(adc_sel_diff), .adc_done(adc_done), .adc_data(adc_data),
        .led_current_source(led_code), .focus_led(focus_led), .zoom_led(zoom_led),
        .zoom_hall_source_pin(zoom_hall_source_pin), .drv_disable(drv_disable), .irq(irq));
    lpas_adc_model u_lpas_adc_model (.clk(clk), .adc_convert(adc_convert), .dly(dly),
        .base(base), .adc_done(adc_done), .adc_data(adc_data));
    initial forever #10 clk = ~clk;
    // sticky observers of the sensor drive during a run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (focus_led) seen_f <= 1'b1;
        if (zoom_led) seen_z <= 1'b1;
        if (zoom_hall_source_pin) seen_h <= 1'b1;
        if (focus_led) code_s <= led_code;
        if (focus_led || zoom_hall_source_pin) md_s <= {adc_mode_current, adc_sel_diff};
        if (adc_convert && !conv_s) begin conv_s <= 1'b1; t_conv <= cyc; end
    end
    task finish_test;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(input [8*12-1:0] nm, input [11:0] got, input [11:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("MISMATCH %0s exp %h got %h", nm, exp, got);
        end
    endtask
    task wr(input [3:0] a, input [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1; reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        rd_v = reg_rdata;
    endtask
    // start a run and clear the sticky seen flags and conv_s; code_s and md_s keep their last values
    task go(input [7:0] c);
        seen_f <= 1'b0; seen_z <= 1'b0; seen_h <= 1'b0; conv_s <= 1'b0;
        t0 = cyc + 1;
        wr(`LPAS_REG_CTRL, c);
    endtask
    // poll the done flag, then check the result pair
    task fin(input avg);
        rd_v = 8'h00;
        for (i = 0; i < 400 && !rd_v[0]; i = i + 1) rd(`LPAS_REG_IRQ_STAT);
        // a hang counts once and the run goes on to the closing report
        if (!rd_v[0]) num_errors = num_errors + 1;
        if (avg) begin
            // four samples take offsets 0..3 in some order: sum 6, so the mean is base plus one
            r = base + 12'h001;
        end else begin
            r = base + k_exp;
            k_exp = k_exp + 2'h1;
        end
        rd(`LPAS_REG_RES_LO); chk("res_lo", rd_v, r[7:0]);
        rd(`LPAS_REG_RES_HI); chk("res_hi", rd_v, r[11:8]);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rd(`LPAS_REG_CTRL); chk("ctrl_rst", rd_v, 12'h04);
        rd(`LPAS_REG_ADC_DIV); chk("div_rst", rd_v, 12'h03);
        rd(`LPAS_REG_THR_HI); chk("thr_rst", rd_v, 12'h0F);
        rd(4'hC); chk("unmapped", rd_v, 12'h00);
        // focus, current, averaged, with a start poked while busy
        wr(`LPAS_REG_LED, 8'h0A); wr(`LPAS_REG_SETL_LO, 8'h02); wr(`LPAS_REG_IRQ_MASK, 8'h01);
        base = 12'h123;
        go(8'h0D); wr(`LPAS_REG_CTRL, 8'h0F);
        fin(1'b1);
        chk("settle", (t_conv - t0 >= 100 && t_conv - t0 <= 106), 12'h1);
        chk("leds", {seen_f, seen_z}, 12'h2);
        chk("code", code_s, 12'h0A);
        chk("md_cur", md_s, 12'h2);
        chk("irq_on", irq, 12'h1);
        // a flag written at an edge only stands after that edge, so look one edge later
        wr(`LPAS_REG_IRQ_STAT, 8'h01); @(posedge clk); chk("irq_clr", irq, 12'h0);
        // zoom, voltage, single slow sample, interrupt masked
        wr(`LPAS_REG_SETL_LO, 8'h00); wr(`LPAS_REG_IRQ_MASK, 8'h00);
        base = 12'h8E5; dly = 4'h9;
        go(8'h03); fin(1'b0);
        chk("hall", {seen_h, seen_f, seen_z}, 12'h4);
        chk("md_volt", md_s, 12'h1);
        chk("irq_mask", irq, 12'h0);
        wr(`LPAS_REG_IRQ_MASK, 8'h01); @(posedge clk); chk("irq_unmask", irq, 12'h1);
        wr(`LPAS_REG_IRQ_STAT, 8'h01);
        // zoom LED in current mode; threshold reached stops the drivers until cleared
        wr(`LPAS_REG_THR_LO, 8'h00); wr(`LPAS_REG_THR_HI, 8'h01);
        base = 12'h200; dly = 4'h2;
        go(8'h1B); fin(1'b0);
        chk("leds_zoom", {seen_f, seen_z}, 12'h1);
        chk("drv", drv_disable, 12'h1);
        rd(`LPAS_REG_IRQ_STAT); chk("irq_thr", rd_v, 12'h03);
        wr(`LPAS_REG_STATUS, 8'h02); @(posedge clk); chk("drv_clr", drv_disable, 12'h0);
        finish_test;
    end
endmodule // lpas_seq_bench
